// >>> src/sfr_page_pkg.sv
// constants for the register page decoder and page stack
package sfr_page_pkg;
  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam logic [7:0] PAGE_SELECT_ADDR = 8'hA7;
  localparam logic [7:0] PAGE_STACK_CTRL_ADDR = 8'hCF;
  localparam logic [7:0] PAGE_STACK_VIEW_ADDR = 8'hD7;
  localparam logic [7:0] PAGE_SELECT_RESET = 8'h00;
  localparam logic [7:0] STACK_ENTRY_RESET = 8'h00;
  localparam int STACK_DEPTH = 5;
  localparam logic [2:0] STACK_LAST_IDX = 3'h4;
  // page_stack_ctrl fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_IDX_LSB = 4;
  localparam int CTRL_IDX_MSB = 6;
  localparam logic AUTO_EN_RESET = 1'b1;
  localparam logic [2:0] STACK_IDX_RESET = 3'h0;
  localparam logic [3:0] BIT_ADDR_NIBBLE_LO = 4'h0;
  localparam logic [3:0] BIT_ADDR_NIBBLE_HI = 4'h8;
  // pages on which the peripheral-side decode answers (A, B, C); PERIPH_PAGE_ALL is not used by the decode
  localparam logic [7:0] PERIPH_PAGE_A = 8'h00;
  localparam logic [7:0] PERIPH_PAGE_B = 8'h10;
  localparam logic [7:0] PERIPH_PAGE_C = 8'h20;
  localparam logic [7:0] PERIPH_PAGE_ALL = 8'hFF;
endpackage

// >>> src/sfr_paging_page_stack.sv
// register page decoder with five-deep interrupt page stack
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// How it works
// - direct accesses 0x80..0xFF go to registers
// - bit access only at addresses ending 0/8
// - 256 pages chosen by page select
// - core registers every page, peripherals some
// - interrupt saves page, return restores it
// - five entries, index picks, view reads
// - index 0 is current page, 4 bottom
// - entry shifts down, current page to 1
// - entry loads page of interrupt source
// - return loads page from 1, shifts up
// - control bit enables automatic page switching
// - every reset sets automatic switching enable
//////////////////////////////////////////////////////////////////////////////
module sfr_paging_page_stack
  import sfr_page_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // core direct-address access
  input wire logic [7:0] i_addr,
  input wire logic i_direct,
  input wire logic i_bit_op,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  // interrupt events from the core
  input wire logic i_irq_entry,
  input wire logic [7:0] i_irq_page,
  input wire logic i_return_from_interrupt,
  // read data and decode results
  output logic [7:0] o_rdata,
  output logic o_sfr_sel,
  output logic o_ram_sel,
  output logic o_bit_ok,
  output logic o_periph_hit,
  output logic [7:0] o_page,
  output logic o_auto_page_switch_en
);

  logic [7:0] page_select_reg;
  logic [7:0] stack_mem [1:STACK_DEPTH-1];
  logic auto_page_switch_en;
  logic [2:0] stack_read_index;
  logic [7:0] view;
  logic sfr_hit;

  function automatic logic is_sfr(input logic [7:0] a, input logic d);
    is_sfr = d && (a >= SFR_BASE);
  endfunction

  function automatic logic bit_capable(input logic [7:0] a);
    bit_capable = (a[3:0] == BIT_ADDR_NIBBLE_LO) || (a[3:0] == BIT_ADDR_NIBBLE_HI);
  endfunction

  assign sfr_hit = is_sfr(i_addr, i_direct);

  ////////////////////////////////////////////////////////////////////////////
  // page select register and automatic switching
  wire wr_page = sfr_hit && i_wr && !i_bit_op && (i_addr == PAGE_SELECT_ADDR);
  wire wr_ctrl = sfr_hit && i_wr && !i_bit_op && (i_addr == PAGE_STACK_CTRL_ADDR);
  wire do_push = i_irq_entry && auto_page_switch_en;
  wire do_pop = i_return_from_interrupt && !i_irq_entry && auto_page_switch_en;

  // interrupt entry wins over a same-cycle software write so context is kept
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      page_select_reg <= PAGE_SELECT_RESET;
    end else if (do_push) begin
      page_select_reg <= i_irq_page;
    end else if (do_pop) begin
      page_select_reg <= stack_mem[1];
    end else if (wr_page) begin
      page_select_reg <= i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      auto_page_switch_en <= AUTO_EN_RESET;
      stack_read_index <= STACK_IDX_RESET;
    end else if (wr_ctrl) begin
      auto_page_switch_en <= i_wdata[CTRL_EN_BIT];
      stack_read_index <= i_wdata[CTRL_IDX_MSB:CTRL_IDX_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // page stack entries 1..4; entry 0 is the page select register itself
  generate
    for (genvar k = 1; k < STACK_DEPTH; k++) begin : g_stack
      logic [7:0] push_src;
      logic [7:0] pop_src;
      if (k == 1) begin : g_top
        assign push_src = page_select_reg;
      end else begin : g_inner
        assign push_src = stack_mem[k-1];
      end
      // bottom entry is kept on return since nothing lies below it
      if (k == STACK_DEPTH - 1) begin : g_bottom
        assign pop_src = stack_mem[k];
      end else begin : g_upper
        assign pop_src = stack_mem[k+1];
      end
      always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
          stack_mem[k] <= STACK_ENTRY_RESET;
        end else if (do_push) begin
          stack_mem[k] <= push_src;
        end else if (do_pop) begin
          stack_mem[k] <= pop_src;
        end
      end
    end
  endgenerate

  // indices 5..7 read as zero rather than alias a real entry
  always_comb begin
    if (stack_read_index == 3'h0) begin
      view = page_select_reg;
    end else if (stack_read_index <= STACK_LAST_IDX) begin
      view = stack_mem[stack_read_index];
    end else begin
      view = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path and decode outputs, all registered
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_rdata <= 8'h00;
    end else if (sfr_hit && i_rd) begin
      case (i_addr)
        PAGE_SELECT_ADDR: o_rdata <= page_select_reg;
        PAGE_STACK_CTRL_ADDR: o_rdata <= {1'b0, stack_read_index, 3'h0, auto_page_switch_en};
        PAGE_STACK_VIEW_ADDR: o_rdata <= view;
        default: o_rdata <= 8'h00; // unoccupied addresses: undefined for software
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_sfr_sel <= 1'b0;
      o_ram_sel <= 1'b0;
      o_bit_ok <= 1'b0;
      o_periph_hit <= 1'b0;
    end else begin
      o_sfr_sel <= sfr_hit && (i_rd || i_wr);
      o_ram_sel <= !sfr_hit && (i_rd || i_wr);
      o_bit_ok <= sfr_hit && bit_capable(i_addr);
      // peripheral registers answer only on their pages; core ones on all
      o_periph_hit <= sfr_hit && ((page_select_reg == PERIPH_PAGE_A) ||
        (page_select_reg == PERIPH_PAGE_B) || (page_select_reg == PERIPH_PAGE_C));
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_page <= PAGE_SELECT_RESET;
      o_auto_page_switch_en <= AUTO_EN_RESET;
    end else begin
      o_page <= (do_push ? i_irq_page : do_pop ? stack_mem[1] :
        wr_page ? i_wdata : page_select_reg);
      o_auto_page_switch_en <= wr_ctrl ? i_wdata[CTRL_EN_BIT] : auto_page_switch_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_push_loads_page: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    do_push |=> page_select_reg == $past(i_irq_page))
    else $error("page not loaded on interrupt entry");
  a_push_saves_top: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    do_push |=> stack_mem[1] == $past(page_select_reg) && stack_mem[4] == $past(stack_mem[3]))
    else $error("stack not shifted down on entry");
  a_pop_restores: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    do_pop |=> page_select_reg == $past(stack_mem[1]) && stack_mem[1] == $past(stack_mem[2]))
    else $error("page not restored on return");
  a_round_trip: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    do_push ##1 (do_pop && !wr_page) |=> page_select_reg == $past(page_select_reg, 2))
    else $error("page lost over interrupt");
  a_disabled_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (!auto_page_switch_en && !wr_page) |=> $stable(page_select_reg) && $stable(stack_mem[1]))
    else $error("page changed while switching off");
  a_index0_view: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (sfr_hit && i_rd && i_addr == PAGE_STACK_VIEW_ADDR && stack_read_index == 3'h0)
    |=> o_rdata == $past(page_select_reg))
    else $error("index zero not current page");
  a_reset_enable: assert property (@(posedge i_ref_clk)
    !i_rstn |=> auto_page_switch_en)
    else $error("enable not set by reset");
  a_bit_decode: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (sfr_hit && i_addr[2:0] != 3'h0) |=> !o_bit_ok)
    else $error("bit access allowed at wrong address");
  a_ram_route: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_direct && i_addr[7] && i_wr) |=> o_sfr_sel && !o_ram_sel)
    else $error("register access routed to ram");
  a_page_write: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (wr_page && !do_push && !do_pop) |=> page_select_reg == $past(i_wdata))
    else $error("page select write lost");
  a_bitop_refused: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (sfr_hit && i_wr && i_bit_op && !bit_capable(i_addr) && !do_push && !do_pop)
    |=> $stable(page_select_reg) && $stable(auto_page_switch_en))
    else $error("bit write changed byte-only register");
  a_view_bottom: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (sfr_hit && i_rd && i_addr == PAGE_STACK_VIEW_ADDR && stack_read_index == STACK_LAST_IDX)
    |=> o_rdata == $past(stack_mem[4]))
    else $error("index four not bottom entry");
  a_page_mirror: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    o_page == page_select_reg)
    else $error("page output out of step");
  a_ctrl_write: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    wr_ctrl |=> auto_page_switch_en == $past(i_wdata[CTRL_EN_BIT]) &&
      stack_read_index == $past(i_wdata[CTRL_IDX_MSB:CTRL_IDX_LSB]))
    else $error("control write lost");

endmodule // sfr_paging_page_stack

// >>> sim/core_model.sv
// core-side model issuing direct accesses and interrupt events
`timescale 1ns/1ns
module core_model (
  // clock
  input wire logic i_ref_clk,
  // requests towards the register block
  output logic [7:0] o_addr,
  output logic o_direct,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_wdata,
  output logic o_irq,
  output logic [7:0] o_irq_page,
  output logic o_return_from_interrupt
);
  initial {o_addr, o_direct, o_wr, o_rd, o_wdata, o_irq, o_irq_page, o_return_from_interrupt} = '0;
  // c is {direct, wr, rd, entry, return}; v is both write data and entry page
  // read data is judged only at occupied addresses
  task automatic req(input logic [4:0] c, input logic [7:0] a, v);
    @(posedge i_ref_clk);
    {o_direct, o_wr, o_rd, o_irq, o_return_from_interrupt} <= c;
    o_addr <= a;
    o_wdata <= v;
    o_irq_page <= v;
    @(posedge i_ref_clk);
    {o_wr, o_rd, o_irq, o_return_from_interrupt} <= 4'h0;
    // stale data inverted so a late capture shows up
    o_wdata <= ~v;
    o_irq_page <= ~v;
    #1;
  endtask
  // entry then return on the very next cycle, as for a one-instruction handler
  task automatic irq_burst(input logic [7:0] p);
    @(posedge i_ref_clk);
    {o_irq, o_irq_page} <= {1'b1, p};
    @(posedge i_ref_clk);
    {o_irq, o_return_from_interrupt} <= 2'b01;
    @(posedge i_ref_clk);
    o_return_from_interrupt <= 1'b0;
    o_irq_page <= ~p;
    #1;
  endtask
endmodule // core_model

// >>> sim/sfr_paging_page_stack_tb_top.sv
// self-checking bench for the page decoder and page stack
`timescale 1ns/1ns
module sfr_paging_page_stack_tb_top;
  import sfr_page_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [7:0] i_addr, i_wdata, i_irq_page, o_rdata, o_page;
  logic i_direct, i_wr, i_rd, i_irq_entry, i_return_from_interrupt, o_sfr_sel, o_ram_sel;
  logic o_bit_ok, o_periph_hit, o_auto_page_switch_en;
  logic i_bit_op = 1'b0;
  logic [7:0] pg [5] = '{8'h45, 8'h44, 8'h43, 8'h42, 8'h41};
  int n_errors = 0;
  int checked = 0;
  always #20 i_ref_clk = ~i_ref_clk;
  core_model i_core (.i_ref_clk, .o_addr(i_addr), .o_direct(i_direct), .o_wr(i_wr), .o_rd(i_rd),
    .o_wdata(i_wdata), .o_irq(i_irq_entry), .o_irq_page(i_irq_page),
    .o_return_from_interrupt(i_return_from_interrupt));
  sfr_paging_page_stack i_dut (.i_ref_clk, .i_rstn, .i_addr, .i_direct, .i_bit_op, .i_wr,
    .i_rd, .i_wdata, .i_irq_entry, .i_irq_page, .i_return_from_interrupt, .o_rdata, .o_sfr_sel,
    .o_ram_sel, .o_bit_ok, .o_periph_hit, .o_page, .o_auto_page_switch_en);
  task automatic chk(input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic t_reset;
    @(posedge i_ref_clk);
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    i_core.req(5'h14, PAGE_STACK_CTRL_ADDR, 8'h00);
    chk(o_rdata, 8'h01);
    chk(o_page, PAGE_SELECT_RESET);
    $display("reset test done");
  endtask
  task automatic t_decode;
    i_core.req(5'h18, PAGE_SELECT_ADDR, 8'h33);
    i_core.req(5'h14, 8'h89, 8'h00);
    chk({o_sfr_sel, o_ram_sel, o_bit_ok, o_periph_hit}, 8'h08);
    i_core.req(5'h18, PAGE_SELECT_ADDR, PERIPH_PAGE_B);
    i_core.req(5'h14, 8'h88, 8'h00);
    chk({o_sfr_sel, o_ram_sel, o_bit_ok, o_periph_hit}, 8'h0b);
    // bit instruction on a byte-only register must not write it
    @(posedge i_ref_clk);
    i_bit_op <= 1'b1;
    i_core.req(5'h18, PAGE_SELECT_ADDR, 8'h5a);
    chk({o_sfr_sel, o_ram_sel, o_bit_ok, o_periph_hit}, 8'h09);
    chk(o_page, PERIPH_PAGE_B);
    @(posedge i_ref_clk);
    i_bit_op <= 1'b0;
    i_core.req(5'h04, PAGE_SELECT_ADDR, 8'h00);
    chk({o_sfr_sel, o_ram_sel, o_bit_ok, o_periph_hit}, 8'h04);
    chk(o_page, PERIPH_PAGE_B);
    $display("decode test done");
  endtask
  task automatic t_stack;
    for (int k = 4; k >= 0; k--) begin
      i_core.req(5'h02, 8'h00, pg[k]);
      chk(o_page, pg[k]);
    end
    for (int k = 0; k < 5; k++) begin
      i_core.req(5'h18, PAGE_STACK_CTRL_ADDR, 8'(k << 4) | 8'h01);
      i_core.req(5'h14, PAGE_STACK_VIEW_ADDR, 8'h00);
      chk(o_rdata, pg[k]);
    end
    for (int k = 1; k < 6; k++) begin
      i_core.req(5'h01, 8'h00, 8'h00);
      chk(o_page, pg[k > 4 ? 4 : k]);
    end
    // back-to-back entry and return must bring the page straight back
    i_core.irq_burst(8'h66);
    chk(o_page, pg[4]);
    // switching off: entry and return must leave page and stack alone
    i_core.req(5'h18, PAGE_STACK_CTRL_ADDR, 8'h10);
    i_core.req(5'h02, 8'h00, 8'h77);
    chk({o_page[6:0], o_auto_page_switch_en}, {pg[4][6:0], 1'b0});
    i_core.req(5'h01, 8'h00, 8'h00);
    i_core.req(5'h14, PAGE_STACK_VIEW_ADDR, 8'h00);
    chk(o_rdata, pg[4]);
    chk(o_page, pg[4]);
    $display("stack test done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    t_reset();
    t_decode();
    t_stack();
    t_reset();
    complete_run();
  end
endmodule // sfr_paging_page_stack_tb_top
